// ==== hdl/bal_pkg.sv ====
// package: opcodes, flag layout, request carrier and constants of the byte arithmetic/logic unit
// Function
// [RULE1] add registers, optional carry, five flags, one cycle
// [RULE2] word add immediate to pair, two cycles
// [RULE3] word subtract immediate from pair, two cycles
// [RULE4] subtract immediate from register, one cycle
// [RULE5] register minus source minus carry, one cycle
// [RULE6] register minus immediate minus carry, one cycle
// [RULE7] and with register/immediate, flags z n v
// [RULE8] or with register/immediate, flags z n v
// [RULE9] clear bits: and with ff minus mask
// [RULE10] set bits: or with mask, one cycle
// [RULE11] test: and register with itself, unchanged
// [RULE12] flags not affected keep their values
package bal_pkg;

  localparam int unsigned BYTE_W       = 8;            // datapath byte width
  localparam int unsigned WORD_W       = 16;           // register pair width
  localparam int unsigned BYTE_CYCLES  = 1;            // cycles of any byte operation
  localparam int unsigned WORD_CYCLES  = 2;            // cycles of a pair operation
  localparam logic [7:0]  ALL_ONES     = 8'hFF;        // base of the clear-bits complement
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;        // zero byte
  localparam logic [15:0] WORD_ZERO    = 16'h0000;     // zero word, result reset value

  // operations the decoder may request
  typedef enum logic [3:0] {
    add_op,
    add_carry_op,
    sub_op,
    sub_immediate_op,
    sub_with_carry_op,
    sub_carry_immediate_op,
    and_op,
    and_immediate_op,
    or_op,
    or_immediate_op,
    clear_bits_op,
    set_bits_op,
    test_register_op,
    word_add_immediate_op,
    word_sub_immediate_op
  } bal_op_t;

  // status flags held by the unit
  typedef struct packed {
    logic h;  // half carry
    logic s;  // sign, set to n xor v by pair operations only
    logic v;  // two's complement overflow
    logic n;  // negative
    logic z;  // zero
    logic c;  // carry / borrow
  } bal_flags_t;

  localparam bal_flags_t FLAGS_RESET = '0;             // all flags clear after reset

  // one request from the decoder, operands already read from the register file
  typedef struct packed {
    bal_op_t    op;                // operation
    logic [7:0] dst;               // destination register value
    logic [7:0] source_register;   // second register value
    logic [7:0] imm;               // immediate constant or mask
    logic [7:0] pair_hi;           // high register of the pair
    logic [7:0] pair_lo;           // low register of the pair
  } bal_req_t;

  // pair operations take the two-cycle path
  function automatic logic is_word_op(input bal_op_t op);
    return (op == word_add_immediate_op) || (op == word_sub_immediate_op);
  endfunction

  // logic operations touch only z, n and v
  function automatic logic is_logic_op(input bal_op_t op);
    return (op == and_op) || (op == and_immediate_op) || (op == or_op) ||
           (op == or_immediate_op) || (op == clear_bits_op) || (op == set_bits_op) ||
           (op == test_register_op);
  endfunction

endpackage

// ==== hdl/bal_addsub8.sv ====
// module: 8-bit adder/subtractor with carry, half carry and overflow
`timescale 1ns/1ps
module bal_addsub8
  import bal_pkg::*;
(
  input  wire logic [7:0] a_i,     // minuend or first addend
  input  wire logic [7:0] b_i,     // subtrahend or second addend
  input  wire logic       cin_i,   // carry in, or borrow in when subtracting
  input  wire logic       sub_i,   // high selects a - b - cin
  output logic      [7:0] res_o,   // eight-bit result
  output logic            c_o,     // carry out, or borrow out when subtracting
  output logic            h_o,     // carry or borrow across bit 3
  output logic            v_o      // signed overflow
);

  logic [7:0] b_eff;   // b inverted for subtraction
  logic       c_eff;   // carry in inverted for subtraction
  logic [8:0] sum;     // full sum with carry out
  logic [4:0] nib;     // low nibble sum for half carry

  // subtraction as a + ~b + ~borrow; carries invert back into borrows
  always_comb begin
    b_eff = sub_i ? ~b_i : b_i;
    c_eff = sub_i ? ~cin_i : cin_i;
    sum   = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, c_eff};
    nib   = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
    res_o = sum[7:0];
    c_o   = sum[8] ^ sub_i;
    h_o   = nib[4] ^ sub_i;
    v_o   = (a_i[7] == b_eff[7]) && (sum[7] != a_i[7]);
  end

endmodule

// ==== hdl/bal_unit.sv ====
// module: byte arithmetic/logic execution unit with status flags
`timescale 1ns/1ps
module bal_unit
  import bal_pkg::*;
(
  input  wire logic       sys_clk_i,    // core clock, 20 MHz
  input  wire logic       srst_i,       // synchronous reset, active high
  input  wire logic       req_valid_i,  // decoder presents a request
  input  wire bal_req_t   req_i,        // operation and operands
  output logic            busy_o,       // second cycle of a pair operation
  output logic            wr_byte_o,    // pulse: write result_o[7:0] to destination
  output logic            wr_word_o,    // pulse: write result_o to the pair
  output logic     [15:0] result_o,     // result, byte in low bits
  output bal_flags_t      flags_o       // current status flags
);

  typedef enum logic {
    st_idle,
    st_word_hi
  } bal_state_t;

  bal_state_t state_reg;       // sequencer state
  bal_state_t state_next;      // next sequencer state
  logic [7:0] lo_res_reg;      // low byte of a pair result
  logic       lo_carry_reg;    // carry or borrow out of the low byte
  logic [7:0] hi_src_reg;      // high register of the pair
  logic       word_sub_reg;    // pair operation subtracts
  logic [15:0] result_reg;     // result output register
  logic       wr_byte_reg;     // byte write pulse
  logic       wr_word_reg;     // word write pulse
  logic       busy_reg;        // busy output register, mirrors st_word_hi
  bal_flags_t flags_reg;       // status flags
  bal_flags_t flags_next;      // flags after this cycle

  logic       take;            // request accepted this edge
  logic [7:0] ad_a;            // adder first operand
  logic [7:0] ad_b;            // adder second operand
  logic       ad_cin;          // adder carry in
  logic       ad_sub;          // adder subtracts
  logic [7:0] ad_res;          // adder result
  logic       ad_c;            // adder carry out
  logic       ad_h;            // adder half carry
  logic       ad_v;            // adder overflow
  logic [7:0] lg_res;          // logic unit result
  logic [7:0] byte_res;        // selected byte result
  logic [15:0] word_res;       // assembled pair result

  // a request is refused while the pair operation holds the adder
  assign take = req_valid_i && (state_reg == st_idle);

  // adder operand steering; the single adder serves both bytes of a pair
  always_comb begin
    ad_a   = req_i.dst;
    ad_b   = req_i.source_register;
    ad_cin = 1'b0;
    ad_sub = 1'b0;
    if (state_reg == st_word_hi) begin
      ad_a   = hi_src_reg;         // high byte only ripples the low carry [RULE2] [RULE3]
      ad_b   = BYTE_ZERO;
      ad_cin = lo_carry_reg;
      ad_sub = word_sub_reg;
    end else begin
      case (req_i.op)
        add_op: begin
          ad_b = req_i.source_register;   // [RULE1]
        end
        add_carry_op: begin
          ad_cin = flags_reg.c;           // [RULE1]
        end
        sub_op: begin
          ad_sub = 1'b1;
        end
        sub_immediate_op: begin
          ad_b   = req_i.imm;             // [RULE4]
          ad_sub = 1'b1;
        end
        sub_with_carry_op: begin
          ad_cin = flags_reg.c;           // [RULE5]
          ad_sub = 1'b1;
        end
        sub_carry_immediate_op: begin
          ad_b   = req_i.imm;             // [RULE6]
          ad_cin = flags_reg.c;
          ad_sub = 1'b1;
        end
        word_add_immediate_op: begin
          ad_a = req_i.pair_lo;           // low byte first [RULE2]
          ad_b = req_i.imm;
        end
        word_sub_immediate_op: begin
          ad_a   = req_i.pair_lo;         // [RULE3]
          ad_b   = req_i.imm;
          ad_sub = 1'b1;
        end
        default: begin
          ad_sub = 1'b0;
        end
      endcase
    end
  end

  bal_addsub8 u_addsub (
    .a_i   (ad_a),
    .b_i   (ad_b),
    .cin_i (ad_cin),
    .sub_i (ad_sub),
    .res_o (ad_res),
    .c_o   (ad_c),
    .h_o   (ad_h),
    .v_o   (ad_v)
  );

  // bitwise operations
  always_comb begin
    case (req_i.op)
      and_op:           lg_res = req_i.dst & req_i.source_register;   // [RULE7]
      and_immediate_op: lg_res = req_i.dst & req_i.imm;               // [RULE7]
      or_op:            lg_res = req_i.dst | req_i.source_register;   // [RULE8]
      or_immediate_op:  lg_res = req_i.dst | req_i.imm;               // [RULE8]
      clear_bits_op:    lg_res = req_i.dst & (ALL_ONES - req_i.imm);  // [RULE9]
      set_bits_op:      lg_res = req_i.dst | req_i.imm;               // [RULE10]
      test_register_op: lg_res = req_i.dst & req_i.dst;               // [RULE11]
      default:          lg_res = BYTE_ZERO;
    endcase
  end

  assign byte_res = is_logic_op(req_i.op) ? lg_res : ad_res;
  assign word_res = {ad_res, lo_res_reg};

  // flag computation; untouched flags fall through from flags_reg
  always_comb begin
    flags_next = flags_reg;                                   // [RULE12]
    if (state_reg == st_word_hi) begin
      flags_next.c = ad_c;                                    // [RULE2] [RULE3]
      flags_next.v = ad_v;
      flags_next.n = ad_res[7];
      flags_next.z = (word_res == WORD_ZERO);
      flags_next.s = ad_res[7] ^ ad_v;
    end else if (take && !is_word_op(req_i.op)) begin
      flags_next.z = (byte_res == BYTE_ZERO);
      flags_next.n = byte_res[7];
      if (is_logic_op(req_i.op)) begin
        flags_next.v = 1'b0;                                  // [RULE7] [RULE8] [RULE11]
      end else begin
        flags_next.v = ad_v;                                  // [RULE1] [RULE4] [RULE5] [RULE6]
        flags_next.c = ad_c;
        flags_next.h = ad_h;
      end
    end
  end

  // sequencer: pair operations spend a second cycle on the high byte
  always_comb begin
    case (state_reg)
      st_idle:    state_next = (take && is_word_op(req_i.op)) ? st_word_hi : st_idle;
      st_word_hi: state_next = st_idle;
      default:    state_next = st_idle;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= st_idle;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      // registered copy so busy_o leaves a flip-flop, not a decode
      busy_reg  <= (state_next == st_word_hi);
    end
  end

  // low byte of a pair, held across into the second cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      lo_res_reg   <= BYTE_ZERO;
      lo_carry_reg <= 1'b0;
      hi_src_reg   <= BYTE_ZERO;
      word_sub_reg <= 1'b0;
    end else if (take && is_word_op(req_i.op)) begin
      lo_res_reg   <= ad_res;
      lo_carry_reg <= ad_c;
      hi_src_reg   <= req_i.pair_hi;
      word_sub_reg <= (req_i.op == word_sub_immediate_op);
    end
  end

  // result and write strobes; strobes are one-cycle pulses
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      result_reg  <= WORD_ZERO;
      wr_byte_reg <= 1'b0;
      wr_word_reg <= 1'b0;
    end else begin
      wr_byte_reg <= 1'b0;
      wr_word_reg <= 1'b0;
      if (state_reg == st_word_hi) begin
        result_reg  <= word_res;               // [RULE2] [RULE3]
        wr_word_reg <= 1'b1;
      end else if (take && !is_word_op(req_i.op)) begin
        result_reg  <= {BYTE_ZERO, byte_res};  // [RULE1] [RULE4] [RULE9] [RULE10]
        wr_byte_reg <= 1'b1;
      end
    end
  end

  // status flags
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign busy_o    = busy_reg;
  assign wr_byte_o = wr_byte_reg;
  assign wr_word_o = wr_word_reg;
  assign result_o  = result_reg;
  assign flags_o   = flags_reg;

  // checks
  sequence s_word_take(bal_op_t o);
    req_valid_i && !busy_o && req_i.op == o;
  endsequence

  sequence s_word_done;
    busy_o && !wr_word_o ##1 wr_word_o && !busy_o;
  endsequence

  a_add_result: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE1]
    req_valid_i && !busy_o && req_i.op == add_carry_op |=> wr_byte_o &&
      {flags_o.c, result_o[7:0]} == 9'($past(req_i.dst) + $past(req_i.source_register) + $past(flags_o.c)))
    else $error("add with carry result or carry wrong");

  a_word_add_pair: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE2]
    s_word_take(word_add_immediate_op) |=> s_word_done ##0
      result_o == 16'($past({req_i.pair_hi, req_i.pair_lo}, 2) + $past(req_i.imm, 2)) &&
      flags_o.s == (flags_o.n ^ flags_o.v))
    else $error("word add result or timing wrong");

  a_word_sub_pair: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE3]
    s_word_take(word_sub_immediate_op) |=> s_word_done ##0
      result_o == 16'($past({req_i.pair_hi, req_i.pair_lo}, 2) - $past(req_i.imm, 2)) &&
      flags_o.c == ($past({req_i.pair_hi, req_i.pair_lo}, 2) < 16'($past(req_i.imm, 2))))
    else $error("word subtract result or borrow wrong");

  a_sub_imm_borrow: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE4]
    req_valid_i && !busy_o && req_i.op == sub_immediate_op |=> wr_byte_o &&
      result_o[7:0] == 8'($past(req_i.dst) - $past(req_i.imm)) &&
      flags_o.c == ($past(req_i.dst) < $past(req_i.imm)))
    else $error("subtract immediate wrong");

  a_sub_carry_reg: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE5]
    req_valid_i && !busy_o && req_i.op == sub_with_carry_op |=>
      result_o[7:0] == 8'($past(req_i.dst) - $past(req_i.source_register) - $past(flags_o.c)) &&
      flags_o.z == (result_o[7:0] == BYTE_ZERO))
    else $error("subtract with carry wrong");

  a_sub_carry_imm: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE6]
    req_valid_i && !busy_o && req_i.op == sub_carry_immediate_op |=>
      result_o[7:0] == 8'($past(req_i.dst) - $past(req_i.imm) - $past(flags_o.c)))
    else $error("subtract carry immediate wrong");

  a_and_flags: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE7]
    req_valid_i && !busy_o && req_i.op == and_op |=> !flags_o.v &&
      result_o[7:0] == ($past(req_i.dst) & $past(req_i.source_register)) && flags_o.n == result_o[7])
    else $error("and result or flags wrong");

  a_or_imm_res: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE8]
    req_valid_i && !busy_o && req_i.op == or_immediate_op |=> !flags_o.v &&
      result_o[7:0] == ($past(req_i.dst) | $past(req_i.imm)))
    else $error("or immediate wrong");

  a_clear_bits: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE9]
    req_valid_i && !busy_o && req_i.op == clear_bits_op |=>
      result_o[7:0] == ($past(req_i.dst) & ~$past(req_i.imm)))
    else $error("clear bits wrong");

  a_set_bits: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE10]
    req_valid_i && !busy_o && req_i.op == set_bits_op |=> wr_byte_o &&
      result_o[7:0] == ($past(req_i.dst) | $past(req_i.imm)))
    else $error("set bits wrong");

  a_test_same: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE11]
    req_valid_i && !busy_o && req_i.op == test_register_op |=>
      result_o[7:0] == $past(req_i.dst) && flags_o.z == ($past(req_i.dst) == BYTE_ZERO))
    else $error("test altered value or zero flag");

  a_keep_flags: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE12]
    req_valid_i && !busy_o && is_logic_op(req_i.op) |=>
      flags_o.c == $past(flags_o.c) && flags_o.h == $past(flags_o.h) && flags_o.s == $past(flags_o.s))
    else $error("unaffected flag changed");

  // plain add: sum and carry across bit 3
  a_add_half: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE1]
    req_valid_i && !busy_o && req_i.op == add_op |=> wr_byte_o &&
      result_o[7:0] == 8'($past(req_i.dst) + $past(req_i.source_register)) &&
      flags_o.h == (({1'b0, $past(req_i.dst[3:0])} + {1'b0, $past(req_i.source_register[3:0])}) > 5'h0F))
    else $error("add result or half carry wrong");

  // a request held through busy must not sneak in ahead of the pair write
  a_busy_refuse: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE2]
    req_valid_i && busy_o |=> !wr_byte_o && wr_word_o)
    else $error("request taken while busy");

  // pair subtract leaves the half carry alone
  a_word_keep_h: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE12]
    s_word_take(word_sub_immediate_op) |=> ##1 flags_o.h == $past(flags_o.h, 2))
    else $error("pair operation changed half carry");

endmodule

// ==== sim/bal_decoder_model.sv ====
// decoder stand-in: queues requests and presents them to the unit, holding each until taken
`timescale 1ns/1ps
module bal_decoder_model
  import bal_pkg::*;
(
  input  wire logic sys_clk_i,    // core clock
  input  wire logic srst_i,       // synchronous reset
  input  wire logic busy_i,       // unit refuses while high
  output logic      req_valid_o,  // request present
  output bal_req_t  req_o         // request carrier
);
  bal_req_t pend_q[$];            // requests not yet taken

  // bench hands requests in between clock edges
  task automatic push(input bal_req_t r);
    pend_q.push_back(r);
  endtask

  // drop the head once taken; a refused request is simply held again
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      req_valid_o <= 1'b0;
      req_o       <= '0;
    end else begin
      if (req_valid_o && !busy_i) begin
        pend_q.delete(0);
      end
      if (pend_q.size() > 0) begin
        req_valid_o <= 1'b1;
        req_o       <= pend_q[0];
      end else begin
        // released operands flip so a stale value never looks valid
        req_valid_o <= 1'b0;
        req_o       <= bal_req_t'(~req_o);
      end
    end
  end
endmodule

// ==== sim/test_byte_arith_logic_unit.sv ====
// testbench: self-checking scenarios for the byte arithmetic/logic unit
`timescale 1ns/1ps
module test_byte_arith_logic_unit;
  import bal_pkg::*;
  typedef struct {
    logic [15:0] res;             // expected result
    bal_flags_t  f;               // expected flags
    logic        word;            // pair write expected
  } bal_exp_t;
  logic        sys_clk_i;         // core clock
  logic        srst_i;            // reset
  logic        req_valid_i;       // from decoder model
  bal_req_t    req_i;             // from decoder model
  logic        busy_o;            // unit busy
  logic        wr_byte_o;         // byte write pulse
  logic        wr_word_o;         // pair write pulse
  logic [15:0] result_o;          // unit result
  bal_flags_t  flags_o;           // unit flags
  int          miscompares;       // mismatch count
  int          checks_done;       // comparison count
  int          cyc;               // edge counter
  bal_exp_t    exp_q[$];          // in-order expectations
  int          take_q[$];         // edge of each take
  bal_flags_t  ef;                // running expected flags

  bal_unit dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .busy_o(busy_o), .wr_byte_o(wr_byte_o), .wr_word_o(wr_word_o), .result_o(result_o), .flags_o(flags_o));
  bal_decoder_model model_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .busy_i(busy_o),
    .req_valid_o(req_valid_i), .req_o(req_i));

  // 20 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // reference arithmetic; carry is read from the flags left by the previous operation
  task automatic issue(input bal_op_t op, input logic [7:0] d, s, k, hi, lo);
    bal_exp_t e;
    logic [8:0] t9;
    logic [4:0] t5;
    logic [16:0] t17;
    logic [7:0] b;
    logic cin;
    cin = (op inside {add_carry_op, sub_with_carry_op, sub_carry_immediate_op}) ? ef.c : 1'b0;
    b = (op inside {add_op, add_carry_op, sub_op, sub_with_carry_op, and_op, or_op}) ? s : k;
    if (op == test_register_op) b = d;
    if (op == clear_bits_op) b = 8'hFF - k;
    e.word = 1'b0;
    t9 = {1'b0, d & b};
    case (op)
      add_op, add_carry_op: begin
        t9 = d + b + cin;
        t5 = d[3:0] + b[3:0] + cin;
        ef.c = t9[8];
        ef.h = t5[4];
        ef.v = (d[7] == b[7]) && (t9[7] != d[7]);
      end
      sub_op, sub_immediate_op, sub_with_carry_op, sub_carry_immediate_op: begin
        t9 = d - b - cin;
        t5 = d[3:0] - b[3:0] - cin;
        ef.c = t9[8];
        ef.h = t5[4];
        ef.v = (d[7] != b[7]) && (t9[7] != d[7]);
      end
      word_add_immediate_op, word_sub_immediate_op: begin
        t17 = (op == word_add_immediate_op) ? {hi, lo} + k : {hi, lo} - k;
        e.word = 1'b1;
        ef.c = t17[16];
        ef.v = (op == word_add_immediate_op) ? (!hi[7] && t17[15]) : (hi[7] && !t17[15]);
        ef.n = t17[15];
        ef.z = (t17[15:0] == 16'h0000);
        ef.s = ef.n ^ ef.v;
      end
      default: begin
        // logic family: v cleared, c h s untouched
        if (op inside {or_op, or_immediate_op, set_bits_op}) t9 = {1'b0, d | b};
        ef.v = 1'b0;
      end
    endcase
    if (!e.word) begin
      ef.n = t9[7];
      ef.z = (t9[7:0] == 8'h00);
    end
    e.res = e.word ? t17[15:0] : {8'h00, t9[7:0]};
    e.f = ef;
    exp_q.push_back(e);
    model_u.push('{op, d, s, k, hi, lo});
  endtask

  // note takes, judge every write pulse against the oldest expectation
  always @(posedge sys_clk_i) begin
    bal_exp_t e;
    int t;
    cyc <= cyc + 1;
    if (!srst_i && req_valid_i && !busy_o) take_q.push_back(cyc);
    if (!srst_i && (wr_byte_o || wr_word_o)) begin
      if (exp_q.size() == 0 || take_q.size() == 0) begin
        check(16'hDEAD, 16'h0000);
      end else begin
        e = exp_q.pop_front();
        t = take_q.pop_front();
        check(result_o, e.res);
        check({10'h000, flags_o}, {10'h000, e.f});
        check({15'h0000, wr_word_o}, {15'h0000, e.word});
        check(16'(cyc - t), e.word ? 16'(WORD_CYCLES) : 16'(BYTE_CYCLES));
      end
    end
  end

  // wait, bounded, until every queued operation has written back
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (exp_q.size() > 0) check(16'h0001, 16'h0000);
    repeat (2) @(negedge sys_clk_i);
  endtask

  // reset for 10 edges, then all outputs idle and flags clear
  task automatic t_reset;
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(negedge sys_clk_i);
    check({7'h00, busy_o, wr_byte_o, wr_word_o, flags_o}, 16'h0000);
    check(result_o, 16'h0000);
    ef = FLAGS_RESET;
  endtask

  // back-to-back adds, carry fed forward, zero boundary
  task automatic t_add;
    issue(add_op, 8'h8F, 8'h81, 8'h00, 8'h00, 8'h00);
    issue(add_carry_op, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00);
    issue(add_op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    drain();
  endtask

  // borrow chains through every subtract form
  task automatic t_sub;
    issue(sub_immediate_op, 8'h10, 8'h00, 8'h20, 8'h00, 8'h00);
    issue(sub_with_carry_op, 8'h50, 8'h10, 8'h00, 8'h00, 8'h00);
    issue(sub_carry_immediate_op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    issue(sub_op, 8'h80, 8'h01, 8'h00, 8'h00, 8'h00);
    issue(sub_op, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00);
    issue(sub_carry_immediate_op, 8'h05, 8'h00, 8'h04, 8'h00, 8'h00);
    issue(sub_with_carry_op, 8'h05, 8'hFF, 8'h00, 8'h00, 8'h00);
    drain();
  endtask

  // logic ops after c h v set: v must clear, c h must hold
  task automatic t_logic;
    issue(add_op, 8'h88, 8'h88, 8'h00, 8'h00, 8'h00);
    issue(and_op, 8'hF0, 8'h3C, 8'h00, 8'h00, 8'h00);
    issue(and_immediate_op, 8'h80, 8'h00, 8'hFF, 8'h00, 8'h00);
    issue(or_op, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00);
    issue(or_immediate_op, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00);
    issue(clear_bits_op, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'h00);
    issue(set_bits_op, 8'h00, 8'h00, 8'hA5, 8'h00, 8'h00);
    issue(test_register_op, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00);
    issue(test_register_op, 8'h9C, 8'h00, 8'h00, 8'h00, 8'h00);
    drain();
  endtask

  // pair ops back to back with a byte op held through busy
  task automatic t_word;
    issue(add_op, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00);
    issue(word_add_immediate_op, 8'h00, 8'h00, 8'h01, 8'h7F, 8'hFF);
    issue(or_op, 8'h12, 8'h40, 8'h00, 8'h00, 8'h00);
    issue(word_sub_immediate_op, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00);
    issue(word_add_immediate_op, 8'h00, 8'h00, 8'h01, 8'hFF, 8'hFF);
    issue(word_sub_immediate_op, 8'h00, 8'h00, 8'h01, 8'h80, 8'h00);
    drain();
  endtask

  // the verdict, reached once
  task automatic results;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog well past the fewer than a hundred edges the tests need
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    miscompares++;
    results();
  end

  initial begin
    srst_i = 1'b1;
    miscompares = 0;
    checks_done = 0;
    cyc = 0;
    ef = FLAGS_RESET;
    t_reset();
    t_add();
    t_sub();
    t_logic();
    t_word();
    t_reset();
    t_add();
    results();
  end
endmodule
